// [hdl/imuodr_params.svh]
/*
  Constants of the inertial output data register bank: read offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz mclk and inclusion by its bare name.
*/
// Contract
// - Accel y and z high words are signed, zero reads zero, one count is 1.25 mg over +/-40 g.
// - Each accel axis has a low word of extra bits that forms a 32-bit value with its high word.
// - Temperature is a 16-bit signed value at 0.1 C per count with zero degrees as zero.
// - The elapsed time register gives time since the last sync pulse in 49.02 us counts.
// - Elapsed time is kept only while the sync mode field, bits 4:2, holds scaled mode 010.
// - Each update loads the 16-bit time of its last sample measured from the latest sync edge.
// - The update counter clears on reset or reset command and steps by one per data update.
// - The update counter wraps from its maximum to zero and keeps counting.
// - The update counter reads as a full 16-bit unsigned count.
// - Delta angle is the sum of consecutive rate pairs over one interval over twice the rate.
// - One delta angle result spans the decimation setting plus one samples.
// - The internal sample clock runs at a nominal 2000 samples per second.
// - Delta angle high words are signed, zero is zero, one count is the range over 2^15.
// - Each delta angle has a low word holding its low 16 bits beside the high word.
// - The range variant of 360, 720 or 2160 degrees sets the delta angle scale.
`ifndef IMUODR_PARAMS_SVH
`define IMUODR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
// Register byte offsets; each word also answers at offset plus one.
`define IMUODR_OFS_ACCEL_Y_LOW   7'h14
`define IMUODR_OFS_ACCEL_Y_HIGH  7'h16
`define IMUODR_OFS_ACCEL_Z_LOW   7'h18
`define IMUODR_OFS_ACCEL_Z_HIGH  7'h1a
`define IMUODR_OFS_TEMPERATURE   7'h1c
`define IMUODR_OFS_SYNC_ELAPSED  7'h1e
`define IMUODR_OFS_UPDATE_CNT    7'h22
`define IMUODR_OFS_DTHETA_X_LOW  7'h24
`define IMUODR_OFS_DTHETA_X_HIGH 7'h26
`define IMUODR_OFS_DTHETA_Y_LOW  7'h28
`define IMUODR_OFS_DTHETA_Y_HIGH 7'h2a

////////////////////////////////////////////////////////////////////////
// Fields and reset values.
`define IMUODR_SYNC_MODE_MSB   4
`define IMUODR_SYNC_MODE_LSB   2
`define IMUODR_WORD_RESET      16'h0000
`define IMUODR_CNT_RESET       16'h0000
`define IMUODR_UNMAPPED_DATA   16'h0000

////////////////////////////////////////////////////////////////////////
// Timing: clock, sample rate and time stamp unit.
`define IMUODR_MCLK_HZ         50000000
`define IMUODR_MCLK_PS         20000
`define IMUODR_SAMPLE_SPS      2000
`define IMUODR_SAMPLE_CYCLES   (`IMUODR_MCLK_HZ / `IMUODR_SAMPLE_SPS)
`define IMUODR_TS_LSB_PS       49020000
`define IMUODR_TS_CYCLES       (`IMUODR_TS_LSB_PS / `IMUODR_MCLK_PS)

////////////////////////////////////////////////////////////////////////
// Delta angle scaling: product of pair sum and gain, then a shift.
`define IMUODR_DTHETA_SHIFT    24
`define IMUODR_GAIN_360        16'h4000
`define IMUODR_GAIN_720        16'h2000
`define IMUODR_GAIN_2160       16'h0aab

`endif

// [hdl/imuodr_pkg.sv]
/*
  Types of the inertial output data register bank.
  Assumes the constants header is compiled alongside.
*/
package imuodr_pkg;

  // Sync mode field codes; only scaled mode drives the time stamp.
  typedef enum logic [2:0] {
    IMUODR_SYNC_INTERNAL = 3'h0,
    IMUODR_SYNC_DIRECT   = 3'h1,
    IMUODR_SYNC_SCALED   = 3'h2,
    IMUODR_SYNC_OUTPUT   = 3'h3
  } imuodr_sync_mode_t;

  // Dynamic range variants of the delta angle output.
  typedef enum logic [1:0] {
    IMUODR_RANGE_360  = 2'h0,
    IMUODR_RANGE_720  = 2'h1,
    IMUODR_RANGE_2160 = 2'h2
  } imuodr_range_t;

  // One raw sample set from the sensor front end.
  typedef struct packed {
    logic signed [31:0] accel_y;
    logic signed [31:0] accel_z;
    logic signed [15:0] temp;
    logic signed [31:0] rate_x;
    logic signed [31:0] rate_y;
  } imuodr_sample_t;

  // Register read request.
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
  } imuodr_rdreq_t;

endpackage

// [hdl/imuodr_integ.sv]
/*
  Trapezoidal delta angle integrator for one axis.
  Assumes sample_tick pulses once per sample and last_sample marks the
  final sample of a decimation interval in the same cycle.
*/
`timescale 1ns/100ps
`include "imuodr_params.svh"

module imuodr_integ (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               nrst,
  // Control
  input  wire logic               clear,
  input  wire logic               sample_tick,
  input  wire logic               last_sample,
  input  wire logic        [15:0] gain,
  // Data
  input  wire logic signed [31:0] rate,
  output logic signed      [31:0] result
);
  import imuodr_pkg::*;

  logic signed [31:0] prev_q;
  logic signed [49:0] acc_q;
  logic signed [49:0] pair;
  logic signed [49:0] total;
  logic signed [66:0] scaled;

  ////////////////////////////////////////////////////////////////////
  // Pair sum; the previous sample carries across intervals so no pair is lost.
  assign pair   = 50'(rate) + 50'(prev_q);
  assign total  = acc_q + pair;
  // Dividing by twice the rate is folded into gain and shift.
  assign scaled = 67'(total) * $signed({1'b0, gain});
  assign result = scaled[`IMUODR_DTHETA_SHIFT+31:`IMUODR_DTHETA_SHIFT];

  // Accumulate each sample; restart after the last one of an interval.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_q <= '0;
      acc_q  <= '0;
    end else if (clear) begin
      prev_q <= '0;
      acc_q  <= '0;
    end else if (sample_tick) begin
      prev_q <= rate;
      acc_q  <= last_sample ? '0 : total;
    end
  end

endmodule

// [hdl/imuodr_regs.sv]
/*
  Output data register bank: accelerometer y/z words, temperature,
  sync time stamp, update counter and x/y delta angles.
  Assumes synchronous inputs on mclk, a serial front end that turns
  host frames into the read request port, and a sensor front end that
  holds the sample inputs valid at each internal sample tick.
*/
`timescale 1ns/100ps
`include "imuodr_params.svh"

module imuodr_regs #(
  parameter int SAMPLE_CYCLES = `IMUODR_SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // Reset command from the control logic
  input  wire logic                  reset_cmd,
  // Configuration
  input  wire logic           [15:0] miscellaneous_control,
  input  wire logic           [15:0] decimation_setting,
  input  wire imuodr_pkg::imuodr_range_t range_sel,
  // Sensor front end
  input  wire imuodr_pkg::imuodr_sample_t sample,
  output logic                       sample_tick,
  // External timing pin
  input  wire logic                  sync_pin,
  // Register read port
  input  wire imuodr_pkg::imuodr_rdreq_t rd_req,
  output logic                [15:0] rd_data,
  output logic                       rd_valid,
  // Data ready indication
  output logic                       sample_available_pin
);
  import imuodr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Gain per range variant; wider ranges give smaller counts per degree.
  function automatic logic [15:0] range_gain(input imuodr_range_t r);
    case (r)
      IMUODR_RANGE_360:  range_gain = `IMUODR_GAIN_360;
      IMUODR_RANGE_720:  range_gain = `IMUODR_GAIN_720;
      IMUODR_RANGE_2160: range_gain = `IMUODR_GAIN_2160;
      default:           range_gain = `IMUODR_GAIN_360;
    endcase
  endfunction

  // Word-aligned address match; both bytes of a word hit it.
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a[6:1] == ofs[6:1]);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [15:0] div_q;
  logic [15:0] div_d;
  logic        tick_q;
  logic        tick_d;
  logic        div_end;

  logic [15:0] dec_cnt_q;
  logic [15:0] dec_cnt_d;
  logic        last_sample;
  logic        update;

  logic        sync_prev_q;
  logic        sync_edge;
  logic        scaled_mode;
  logic [11:0] ts_div_q;
  logic [11:0] ts_div_d;
  logic [15:0] ts_cnt_q;
  logic [15:0] ts_cnt_d;
  logic        ts_step;

  logic [15:0] accel_y_low_q;
  logic [15:0] accel_y_high_q;
  logic [15:0] accel_z_low_q;
  logic [15:0] accel_z_high_q;
  logic [15:0] temperature_value_q;
  logic [15:0] sync_elapsed_time_q;
  logic [15:0] update_counter_q;
  logic [15:0] update_counter_d;
  logic [31:0] dtheta_x_q;
  logic [31:0] dtheta_y_q;

  logic signed [31:0] dtheta_x_next;
  logic signed [31:0] dtheta_y_next;
  logic        [15:0] gain;

  logic [15:0] rd_word;
  logic [15:0] rd_data_q;
  logic        rd_valid_q;
  logic        drdy_q;

  ////////////////////////////////////////////////////////////////////
  // Internal sample clock: one tick per sample period of mclk cycles.
  assign div_end = (div_q == 16'(SAMPLE_CYCLES - 1));
  assign div_d   = div_end ? 16'h0000 : div_q + 16'h0001;
  assign tick_d  = div_end;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (reset_cmd) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decimation: an interval spans the setting plus one samples.
  assign last_sample = (dec_cnt_q == decimation_setting);
  assign update      = tick_q & last_sample;
  assign dec_cnt_d   = last_sample ? 16'h0000 : dec_cnt_q + 16'h0001;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dec_cnt_q <= 16'h0000;
    end else if (reset_cmd) begin
      dec_cnt_q <= 16'h0000;
    end else if (tick_q) begin
      dec_cnt_q <= dec_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sync time base. The pin is taken as synchronous, so its edge is
  // found directly; a slower pin would need a synchroniser upstream.
  assign scaled_mode = (miscellaneous_control[`IMUODR_SYNC_MODE_MSB:`IMUODR_SYNC_MODE_LSB]
                        == IMUODR_SYNC_SCALED);
  assign sync_edge   = sync_pin & ~sync_prev_q;
  assign ts_step     = (ts_div_q == 12'(`IMUODR_TS_CYCLES - 1));

  // Restart at each sync edge; the count saturates rather than wrap so
  // a lost sync never reads as a small, plausible time.
  always_comb begin
    ts_div_d = ts_step ? 12'h000 : ts_div_q + 12'h001;
    ts_cnt_d = ts_cnt_q;
    if (ts_step && ts_cnt_q != 16'hffff) begin
      ts_cnt_d = ts_cnt_q + 16'h0001;
    end
    if (sync_edge) begin
      ts_div_d = 12'h000;
      ts_cnt_d = 16'h0000;
    end
    if (!scaled_mode) begin
      ts_div_d = 12'h000;
      ts_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_prev_q <= 1'b0;
      ts_div_q    <= 12'h000;
      ts_cnt_q    <= 16'h0000;
    end else begin
      sync_prev_q <= sync_pin;
      ts_div_q    <= ts_div_d;
      ts_cnt_q    <= ts_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Delta angle integrators, one per axis.
  assign gain = range_gain(range_sel);

  imuodr_integ u_integ_x (
    .mclk        (mclk),
    .nrst        (nrst),
    .clear       (reset_cmd),
    .sample_tick (tick_q),
    .last_sample (last_sample),
    .gain        (gain),
    .rate        (sample.rate_x),
    .result      (dtheta_x_next)
  );

  imuodr_integ u_integ_y (
    .mclk        (mclk),
    .nrst        (nrst),
    .clear       (reset_cmd),
    .sample_tick (tick_q),
    .last_sample (last_sample),
    .gain        (gain),
    .rate        (sample.rate_y),
    .result      (dtheta_y_next)
  );

  ////////////////////////////////////////////////////////////////////
  // Update counter: plain 16-bit binary, wraps through zero.
  assign update_counter_d = update_counter_q + 16'h0001;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      update_counter_q <= `IMUODR_CNT_RESET;
    end else if (reset_cmd) begin
      update_counter_q <= `IMUODR_CNT_RESET;
    end else if (update) begin
      update_counter_q <= update_counter_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output words. All load on the same edge so that a host never sees
  // words from two different updates after a single update.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      accel_y_low_q       <= `IMUODR_WORD_RESET;
      accel_y_high_q      <= `IMUODR_WORD_RESET;
      accel_z_low_q       <= `IMUODR_WORD_RESET;
      accel_z_high_q      <= `IMUODR_WORD_RESET;
      temperature_value_q <= `IMUODR_WORD_RESET;
      dtheta_x_q          <= 32'h0000_0000;
      dtheta_y_q          <= 32'h0000_0000;
    end else if (reset_cmd) begin
      accel_y_low_q       <= `IMUODR_WORD_RESET;
      accel_y_high_q      <= `IMUODR_WORD_RESET;
      accel_z_low_q       <= `IMUODR_WORD_RESET;
      accel_z_high_q      <= `IMUODR_WORD_RESET;
      temperature_value_q <= `IMUODR_WORD_RESET;
      dtheta_x_q          <= 32'h0000_0000;
      dtheta_y_q          <= 32'h0000_0000;
    end else if (update) begin
      accel_y_low_q       <= sample.accel_y[15:0];
      accel_y_high_q      <= sample.accel_y[31:16];
      accel_z_low_q       <= sample.accel_z[15:0];
      accel_z_high_q      <= sample.accel_z[31:16];
      temperature_value_q <= sample.temp;
      dtheta_x_q          <= dtheta_x_next;
      dtheta_y_q          <= dtheta_y_next;
    end
  end

  // Time stamp loads with the update only in scaled mode; otherwise it
  // keeps its last value, which software should then ignore.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_elapsed_time_q <= `IMUODR_WORD_RESET;
    end else if (reset_cmd) begin
      sync_elapsed_time_q <= `IMUODR_WORD_RESET;
    end else if (update && scaled_mode) begin
      sync_elapsed_time_q <= ts_cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read selection; unmapped offsets read as zero.
  assign rd_word =
    hit(rd_req.addr, `IMUODR_OFS_ACCEL_Y_LOW)   ? accel_y_low_q :
    hit(rd_req.addr, `IMUODR_OFS_ACCEL_Y_HIGH)  ? accel_y_high_q :
    hit(rd_req.addr, `IMUODR_OFS_ACCEL_Z_LOW)   ? accel_z_low_q :
    hit(rd_req.addr, `IMUODR_OFS_ACCEL_Z_HIGH)  ? accel_z_high_q :
    hit(rd_req.addr, `IMUODR_OFS_TEMPERATURE)   ? temperature_value_q :
    hit(rd_req.addr, `IMUODR_OFS_SYNC_ELAPSED)  ? sync_elapsed_time_q :
    hit(rd_req.addr, `IMUODR_OFS_UPDATE_CNT)    ? update_counter_q :
    hit(rd_req.addr, `IMUODR_OFS_DTHETA_X_LOW)  ? dtheta_x_q[15:0] :
    hit(rd_req.addr, `IMUODR_OFS_DTHETA_X_HIGH) ? dtheta_x_q[31:16] :
    hit(rd_req.addr, `IMUODR_OFS_DTHETA_Y_LOW)  ? dtheta_y_q[15:0] :
    hit(rd_req.addr, `IMUODR_OFS_DTHETA_Y_HIGH) ? dtheta_y_q[31:16] :
    `IMUODR_UNMAPPED_DATA;

  // Read data is registered; it holds until the next read.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_req.en;
      if (rd_req.en) begin
        rd_data_q <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data ready pulse, set on the same edge as the words load.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drdy_q <= 1'b0;
    end else begin
      drdy_q <= update & ~reset_cmd;
    end
  end

  // Outputs straight from flops.
  assign sample_tick          = tick_q;
  assign rd_data              = rd_data_q;
  assign rd_valid             = rd_valid_q;
  assign sample_available_pin = drdy_q;

endmodule

// [testbench/imuodr_regs_sva.sv]
/*
  Port checker of the output data register bank.
  Assumes it is bound to every imuodr_regs instance, one mclk domain.
*/
`timescale 1ns/100ps

module imuodr_regs_sva #(
  parameter int SAMPLE_CYCLES = 20
) (
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      nrst,
  input wire logic                      reset_cmd,
  // Sample timing
  input wire logic                      sample_tick,
  input wire logic                      sample_available_pin,
  // Read port
  input wire imuodr_pkg::imuodr_rdreq_t rd_req,
  input wire logic               [15:0] rd_data,
  input wire logic                      rd_valid
);
  import imuodr_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Word index of the request; odd byte offsets share the even word.
  wire logic [5:0] rd_word = rd_req.addr[6:1];
  wire logic       mapped  = (rd_word >= 6'h0a && rd_word <= 6'h0f) ||
                             (rd_word >= 6'h11 && rd_word <= 6'h15);

  ////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (rd_req.en |=> rd_valid)
    else $error("read not answered one cycle later");
  a_valid_cause: assert property (rd_valid |-> $past(rd_req.en))
    else $error("read answer without a request");
  // Held data lets a slow host pick up the word late.
  a_data_holds: assert property (!rd_req.en && !reset_cmd |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_req.en && !mapped |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_clear_count: assert property (reset_cmd ##[1:4] (rd_req.en && rd_word == 6'h11)
    |=> rd_data == 16'h0000)
    else $error("counter not cleared by reset command");
  a_tick_gap: assert property (sample_tick |=> !sample_tick [*8])
    else $error("sample ticks too close");
  a_pin_cause: assert property (sample_available_pin |-> $past(sample_tick))
    else $error("data ready without a final sample");
  a_pin_pulse: assert property (sample_available_pin |=> !sample_available_pin)
    else $error("data ready longer than one cycle");

  ////////////////////////////////////////////////////////////////////
  c_update: cover property (sample_available_pin);
  c_unmapped: cover property (rd_req.en && !mapped);
  c_cleared_read: cover property (reset_cmd ##[1:4] rd_req.en);
  c_tick_period: cover property (sample_tick ##SAMPLE_CYCLES sample_tick);
endmodule

bind imuodr_regs imuodr_regs_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) imuodr_regs_sva_i (
  .mclk(mclk), .nrst(nrst), .reset_cmd(reset_cmd), .sample_tick(sample_tick),
  .sample_available_pin(sample_available_pin), .rd_req(rd_req), .rd_data(rd_data),
  .rd_valid(rd_valid)
);

// [testbench/imuodr_host.sv]
/*
  Host model that reads the register bank through its read port.
  Assumes the caller stays in step with mclk between reads.
*/
`timescale 1ns/100ps

module imuodr_host (
  // Clock
  input  wire logic                      mclk,
  // Read port toward the bank
  output imuodr_pkg::imuodr_rdreq_t      rd_req,
  input  wire logic               [15:0] rd_data,
  input  wire logic                      rd_valid
);
  import imuodr_pkg::*;

  initial rd_req = '0;

  // Request held across its taking edge; an idle address is scrambled.
  task automatic read(input logic [6:0] a, output logic [15:0] v, output logic ok);
    @(posedge mclk);
    rd_req <= '{en: 1'b1, addr: a};
    @(posedge mclk);
    rd_req <= '{en: 1'b0, addr: ~a};
    #1;
    v = rd_data;
    ok = rd_valid;
  endtask
endmodule

// [testbench/tb_imuodr_regs.sv]
/*
  Self-checking bench of the output data register bank.
  Assumes the bank, its package, header and the host model are compiled.
*/
`timescale 1ns/100ps
`include "imuodr_params.svh"

module tb_imuodr_regs;
  import imuodr_pkg::*;

  localparam int SC = 40;
  logic          mclk, nrst, reset_cmd, sync_pin, rd_valid, tick, pin;
  logic   [15:0] miscellaneous_control, decimation_setting, rd_data;
  imuodr_range_t rng;
  imuodr_sample_t smp;
  imuodr_rdreq_t rd_req;
  logic   [15:0] exp_w [64];
  logic   [15:0] cnt;
  longint        acc [2];
  longint        prev [2];
  int            fail_count, compares, cyc, seed, n, r, w, t0, t1;

  imuodr_regs #(.SAMPLE_CYCLES(SC)) imuodr_regs_i (
    .mclk(mclk), .nrst(nrst), .reset_cmd(reset_cmd),
    .miscellaneous_control(miscellaneous_control),
    .decimation_setting(decimation_setting), .range_sel(rng), .sample(smp),
    .sample_tick(tick), .sync_pin(sync_pin), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .sample_available_pin(pin));
  imuodr_host imuodr_host_i (.mclk(mclk), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid));

  always #10 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////
  // Rates are kept to 28 bits so no sum can overflow the integrator.
  function automatic imuodr_sample_t rnd_sample();
    return '{accel_y: $random(seed), accel_z: $random(seed), temp: 16'($random(seed)),
             rate_x: $random(seed) >>> 4, rate_y: $random(seed) >>> 4};
  endfunction

  function automatic logic [31:0] dth(longint a);
    longint g;
    g = (rng == IMUODR_RANGE_360) ? `IMUODR_GAIN_360 :
        (rng == IMUODR_RANGE_720) ? `IMUODR_GAIN_720 : `IMUODR_GAIN_2160;
    return 32'((a * g) >>> `IMUODR_DTHETA_SHIFT);
  endfunction

  // Reference bank: integrates every sample, latches words on the last one.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (!nrst || reset_cmd) begin
      acc = '{0, 0};
      prev = '{0, 0};
      n = 0;
      cnt = 16'h0000;
      foreach (exp_w[i]) exp_w[i] = 16'h0000;
    end else if (tick) begin
      acc[0] += smp.rate_x + prev[0];
      acc[1] += smp.rate_y + prev[1];
      prev = '{smp.rate_x, smp.rate_y};
      n++;
      if (n == decimation_setting + 1) begin
        cnt++;
        {exp_w[11], exp_w[10]} = smp.accel_y;
        {exp_w[13], exp_w[12]} = smp.accel_z;
        exp_w[14] = smp.temp;
        exp_w[17] = cnt;
        {exp_w[19], exp_w[18]} = dth(acc[0]);
        {exp_w[21], exp_w[20]} = dth(acc[1]);
        acc = '{0, 0};
        n = 0;
      end
      smp <= rnd_sample();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic rd(logic [6:0] a, logic [15:0] want);
    logic [15:0] v;
    logic        ok;
    imuodr_host_i.read(a, v, ok);
    check("rd_valid", {15'h0, ok}, 16'h0001);
    check($sformatf("word %h", a), v, want);
  endtask

  // Bounded wait for the data ready pulse; returns its cycle.
  task automatic wait_pin(output int t);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (pin !== 1'b1 && k < 400);
    if (k >= 400) fail_count++;
    t = cyc;
  endtask

  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) if (cyc == 20000) begin
    fail_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    seed = 45;
    {mclk, nrst, reset_cmd, sync_pin, fail_count, compares} = '0;
    miscellaneous_control = 16'h0000;
    decimation_setting = 16'h0000;
    rng = IMUODR_RANGE_360;
    smp = rnd_sample();
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rd(7'h22, 16'h0000);
    rd(7'h1f, 16'h0000);
    rd(7'h20, 16'h0000);
    $display("test reset values done");
    // Each round: new decimation and range, period check, full word sweep.
    for (r = 0; r < 6; r++) begin
      @(posedge mclk);
      reset_cmd <= 1'b1;
      decimation_setting <= (r == 0) ? 16'h0000 : 16'($random(seed) & 3);
      rng <= imuodr_range_t'(r % 3);
      miscellaneous_control <= 16'($random(seed)) & 16'hffe3;
      @(posedge mclk);
      reset_cmd <= 1'b0;
      rd(7'h22, 16'h0000);
      wait_pin(t0);
      wait_pin(t1);
      check("update period", 16'(t1 - t0), 16'((decimation_setting + 1) * SC));
      for (w = 10; w <= 21; w++) rd({6'(w), 1'($random(seed))}, exp_w[w]);
      $display("test round %0d done", r);
    end
    // Scaled mode: one elapsed unit is 2451 cycles; value held after leaving.
    // Mode changes land on a rising edge, like every other input.
    @(posedge mclk);
    miscellaneous_control <= 16'h0008;
    @(posedge mclk);
    sync_pin <= 1'b1;
    t0 = cyc;
    @(posedge mclk);
    sync_pin <= 1'b0;
    while (cyc - t0 < 3600) @(posedge mclk);
    wait_pin(t1);
    rd(7'h1e, 16'h0001);
    @(posedge mclk);
    miscellaneous_control <= 16'h0000;
    wait_pin(t1);
    rd(7'h1e, 16'h0001);
    $display("test time stamp done");
    finish_test();
  end
endmodule
